// *** shared/dcc_defs.svh ***
// Register offsets, field positions, reset values and timing counts of the converter control.
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// Register addresses on the special-function-register bus.
`define DCC_ADDR_CONFIG      8'h96
`define DCC_ADDR_CONTROL     8'h97

// Reset values of the two registers.
`define DCC_CONFIG_RST       8'h00
`define DCC_CONTROL_RST      8'h21

// Control register fields.
`define DCC_CTL_MINPW_HI     7
`define DCC_CTL_MINPW_LO     6
`define DCC_CTL_SWSIZE       5
`define DCC_CTL_RSVD         4
`define DCC_CTL_ADCSYNC      3
`define DCC_CTL_VOUT_HI      2
`define DCC_CTL_VOUT_LO      0

// Configuration register fields; bit 7 reads as zero.
`define DCC_CFG_RSVD         7
`define DCC_CFG_DIV_HI       6
`define DCC_CFG_DIV_LO       5
`define DCC_CFG_ADCINV       4
`define DCC_CFG_CONV_CLOCK_INVERT       3
`define DCC_CFG_ILIM         2
`define DCC_CFG_FLOAT        1
`define DCC_CFG_SRC          0

// Reference clock and local oscillator rates.
`define DCC_REF_PERIOD_NS    20
`define DCC_REF_KHZ          50000
`define DCC_LOSC_KHZ         2400
`define DCC_LOSC_CYC         ((`DCC_REF_KHZ + `DCC_LOSC_KHZ / 2) / `DCC_LOSC_KHZ)

// Minimum pulse widths, rounded up to whole reference cycles.
`define DCC_MINPW1_NS        20
`define DCC_MINPW2_NS        40
`define DCC_MINPW3_NS        80
`define DCC_NS2CYC(ns)       (((ns) + `DCC_REF_PERIOD_NS - 1) / `DCC_REF_PERIOD_NS)
`define DCC_MINPW1_CYC       `DCC_NS2CYC(`DCC_MINPW1_NS)
`define DCC_MINPW2_CYC       `DCC_NS2CYC(`DCC_MINPW2_NS)
`define DCC_MINPW3_CYC       `DCC_NS2CYC(`DCC_MINPW3_NS)

// Target output voltages in millivolts, one per select code.
`define DCC_VOUT_MV0         12'h708
`define DCC_VOUT_MV1         12'h76C
`define DCC_VOUT_MV2         12'h7D0
`define DCC_VOUT_MV3         12'h834
`define DCC_VOUT_MV4         12'h960
`define DCC_VOUT_MV5         12'hA8C
`define DCC_VOUT_MV6         12'hBB8
`define DCC_VOUT_MV7         12'hCE4

`endif

// *** shared/dcc_pkg.sv ***
// Types shared by the converter control modules.
package dcc_pkg;

  // Switching cycle state, one-hot.
  typedef enum logic [2:0] {
    ST_DIS = 3'b001,
    ST_ON  = 3'b010,
    ST_OFF = 3'b100
  } dcc_sw_state_t;

endpackage : dcc_pkg

// *** hdl/dcc_tick_div.sv ***
// Programmable tick divider that makes the converter clock enable.
`timescale 1ns/10ps
`include "dcc_defs.svh"

module dcc_tick_div (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  // Control
  input  wire logic       i_en,
  input  wire logic [4:0] i_period,
  // Tick
  output logic            o_tick
);

  logic [4:0] cnt_reg;  // Cycles left before the next tick.
  logic [4:0] cnt_next; // Next count.
  logic       tick_reg; // Registered tick.
  logic       tick_next;

  // A tick fires when the count is spent; the count reloads with period minus one.
  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!i_en) begin
      cnt_next = 5'h00;
    end else if (cnt_reg == 5'h00) begin
      tick_next = 1'b1;
      cnt_next  = i_period - 5'h01;
    end else begin
      cnt_next = cnt_reg - 5'h01;
    end
  end

  // Registers the counter and tick.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cnt_reg  <= 5'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign o_tick = tick_reg;

endmodule : dcc_tick_div

// *** hdl/dcc_converter_control.sv ***
// Converter control: registers, clocking, pulse skipping, sleep and ADC alignment.
// Functional notes
// R1 - Converter clock from local oscillator or system clock.
// R2 - Local oscillator runs near 2.4 MHz.
// R3 - System clock divider yields 1.6 to 3.2 MHz; the code ticks every 1, 2, 4 or 8 reference cycles instead, 6.25 to 50 MHz.
// R4 - Invert bit inverts system clock before divider.
// R5 - Sleep disables converter, output tied to battery.
// R6 - Float bit leaves output floating in sleep.
// R7 - Minimum pulse width code; shorter pulses skipped.
// R8 - Switch size bit: zero large, one small.
// R9 - Software writes zero to control bit 4.
// R10 - Sync bit aligns ADC to quiet period.
// R11 - Software zeroes ADC divisor when sync enabled.
// R12 - Voltage select code maps to target voltage.
// R13 - Divider field divides by 1,2,4,8; ignored locally.
// R14 - Source bit zero local, one system clock.
// R15 - One-cell: off only in sleep; two-cell: off.
`timescale 1ns/10ps
`include "dcc_defs.svh"

module dcc_converter_control (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  // Special-function-register bus
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic [7:0]  i_sfr_wdata,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  output logic      [7:0]  o_sfr_rdata,
  // Power mode and strap
  input  wire logic        i_sleep,
  input  wire logic        i_converter_mode_strap,
  // Regulation demand from the analog loop, in reference cycles
  input  wire logic [7:0]  i_duty_req,
  // Power stage controls
  output logic             o_conv_enable,
  output logic             o_conv_tick,
  output logic             o_conv_clk_inv,
  output logic             o_switch_on,
  output logic             o_pulse_skipped,
  output logic             o_switch_small,
  output logic             o_peak_limit_high,
  output logic             o_out_to_battery,
  output logic      [2:0]  o_output_voltage_select,
  output logic      [11:0] o_target_mv,
  // ADC sampling controls
  output logic             o_adc_sync,
  output logic             o_adc_track_en,
  output logic             o_adc_sar_tick,
  output logic             o_adc_sar_inv
);

  logic [7:0] ctrl_reg;      // Control register.
  logic [7:0] ctrl_next;
  logic [7:0] cfg_reg;       // Configuration register.
  logic [7:0] cfg_next;
  logic [7:0] rdata_reg;     // Read data.
  logic [7:0] rdata_next;
  logic       one_cell_reg;  // Strap captured at reset.
  logic       one_cell_next;
  logic       en_reg;        // Converter enable.
  logic       en_next;
  logic       bat_reg;       // Output tied to battery.
  logic       bat_next;

  // Register writes and reads; unmapped reads return zero.
  always_comb begin
    ctrl_next  = ctrl_reg;
    cfg_next   = cfg_reg;
    rdata_next = rdata_reg;
    if (i_sfr_wr && i_sfr_addr == `DCC_ADDR_CONTROL) begin
      ctrl_next = i_sfr_wdata; // R9
    end
    if (i_sfr_wr && i_sfr_addr == `DCC_ADDR_CONFIG) begin
      cfg_next = i_sfr_wdata & 8'h7F;
    end
    if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        `DCC_ADDR_CONTROL: rdata_next = ctrl_reg;
        `DCC_ADDR_CONFIG:  rdata_next = cfg_reg;
        default:           rdata_next = 8'h00;
      endcase
    end
  end

  // Power mode: the strap is sampled while reset is held.
  always_comb begin
    one_cell_next = i_srst ? i_converter_mode_strap : one_cell_reg;
    en_next       = one_cell_reg && !i_sleep; // R5 R15
    bat_next      = one_cell_reg && i_sleep && !cfg_reg[`DCC_CFG_FLOAT]; // R5 R6
  end

  // Registers the bus and power mode state.
  always_ff @(posedge i_ref_clk) begin
    one_cell_reg <= one_cell_next;
    if (i_srst) begin
      ctrl_reg  <= `DCC_CONTROL_RST;
      cfg_reg   <= `DCC_CONFIG_RST;
      rdata_reg <= 8'h00;
      en_reg    <= 1'b0;
      bat_reg   <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      cfg_reg   <= cfg_next;
      rdata_reg <= rdata_next;
      en_reg    <= en_next;
      bat_reg   <= bat_next;
    end
  end

  // Converter clock period in reference cycles.
  logic [4:0] period;
  always_comb begin
    if (!cfg_reg[`DCC_CFG_SRC]) begin
      period = 5'(`DCC_LOSC_CYC); // R1 R2 R14
    end else begin
      unique case (cfg_reg[`DCC_CFG_DIV_HI:`DCC_CFG_DIV_LO]) // R3 R13
        2'b00: period = 5'h01;
        2'b01: period = 5'h02;
        2'b10: period = 5'h04;
        2'b11: period = 5'h08;
      endcase
    end
  end

  logic conv_tick; // One-cycle converter clock enable.

  // The converter clock only runs while the converter is enabled.
  dcc_tick_div u_div (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_en      (en_reg),
    .i_period  (period),
    .o_tick    (conv_tick)
  );

  // Minimum pulse width in reference cycles.
  logic [7:0] min_cyc;
  always_comb begin
    unique case (ctrl_reg[`DCC_CTL_MINPW_HI:`DCC_CTL_MINPW_LO]) // R7
      2'b00: min_cyc = 8'h00;
      2'b01: min_cyc = 8'(`DCC_MINPW1_CYC);
      2'b10: min_cyc = 8'(`DCC_MINPW2_CYC);
      2'b11: min_cyc = 8'(`DCC_MINPW3_CYC);
    endcase
  end

  dcc_pkg::dcc_sw_state_t st_reg;   // Switching state.
  dcc_pkg::dcc_sw_state_t st_next;
  logic [7:0]             on_reg;   // Remaining on cycles.
  logic [7:0]             on_next;
  logic                   skip_reg; // Pulse skipped strobe.
  logic                   skip_next;
  logic                   too_short;

  // Each converter tick starts a pulse unless the demand is zero or shorter than the minimum.
  always_comb begin
    st_next   = st_reg;
    on_next   = on_reg;
    skip_next = 1'b0;
    too_short = (i_duty_req == 8'h00) || (i_duty_req < min_cyc); // R7
    if (!en_reg) begin
      st_next = dcc_pkg::ST_DIS;
      on_next = 8'h00;
    end else if (conv_tick) begin
      if (too_short) begin
        st_next   = dcc_pkg::ST_OFF; // R7
        skip_next = 1'b1;
      end else begin
        st_next = dcc_pkg::ST_ON;
        on_next = i_duty_req - 8'h01;
      end
    end else begin
      unique case (st_reg)
        dcc_pkg::ST_ON: begin
          if (on_reg == 8'h00) begin
            st_next = dcc_pkg::ST_OFF;
          end else begin
            on_next = on_reg - 8'h01;
          end
        end
        dcc_pkg::ST_OFF: st_next = dcc_pkg::ST_OFF;
        dcc_pkg::ST_DIS: st_next = dcc_pkg::ST_OFF;
        default:         st_next = dcc_pkg::ST_DIS;
      endcase
    end
  end

  // Registers the switching state.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_reg   <= dcc_pkg::ST_DIS;
      on_reg   <= 8'h00;
      skip_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      on_reg   <= on_next;
      skip_reg <= skip_next;
    end
  end

  // Target voltage for the regulation loop.
  always_comb begin
    unique case (ctrl_reg[`DCC_CTL_VOUT_HI:`DCC_CTL_VOUT_LO]) // R12
      3'b000: o_target_mv = `DCC_VOUT_MV0;
      3'b001: o_target_mv = `DCC_VOUT_MV1;
      3'b010: o_target_mv = `DCC_VOUT_MV2;
      3'b011: o_target_mv = `DCC_VOUT_MV3;
      3'b100: o_target_mv = `DCC_VOUT_MV4;
      3'b101: o_target_mv = `DCC_VOUT_MV5;
      3'b110: o_target_mv = `DCC_VOUT_MV6;
      3'b111: o_target_mv = `DCC_VOUT_MV7;
    endcase
  end

  // Output decode from the registers and state.
  assign o_sfr_rdata             = rdata_reg;
  assign o_conv_enable           = en_reg;
  assign o_conv_tick             = conv_tick;
  assign o_conv_clk_inv          = cfg_reg[`DCC_CFG_SRC] & cfg_reg[`DCC_CFG_CONV_CLOCK_INVERT]; // R4
  assign o_switch_on             = (st_reg == dcc_pkg::ST_ON);
  assign o_pulse_skipped         = skip_reg;
  assign o_switch_small          = ctrl_reg[`DCC_CTL_SWSIZE]; // R8
  assign o_peak_limit_high       = cfg_reg[`DCC_CFG_ILIM];
  assign o_out_to_battery        = bat_reg;
  assign o_output_voltage_select = ctrl_reg[`DCC_CTL_VOUT_HI:`DCC_CTL_VOUT_LO];
  // ADC tracking sits in the off part of the switching cycle while synced.
  assign o_adc_sync              = ctrl_reg[`DCC_CTL_ADCSYNC];
  assign o_adc_track_en          = !o_adc_sync || (st_reg == dcc_pkg::ST_OFF); // R10
  assign o_adc_sar_tick          = o_adc_sync & conv_tick; // R10
  assign o_adc_sar_inv           = o_adc_sync & ~cfg_reg[`DCC_CFG_ADCINV]; // R10

  // Helper: cycles since the previous tick and the period it was made with.
  // The divider reloads one cycle before its tick shows, so the period that
  // spaces the next tick is the one seen a cycle before this tick.
  logic [5:0] gap_reg;
  logic [4:0] gap_per_reg;
  logic [4:0] gap_src_reg; // Period one cycle back, the value the divider reloads with.
  logic       gap_ok_reg;
  always_ff @(posedge i_ref_clk) begin
    gap_src_reg <= period;
    if (i_srst || !en_reg) begin
      gap_reg     <= 6'h00;
      gap_per_reg <= 5'h00;
      gap_ok_reg  <= 1'b0;
    end else if (conv_tick) begin
      gap_reg     <= 6'h01;
      gap_per_reg <= gap_src_reg;
      gap_ok_reg  <= 1'b1;
    end else if (gap_reg != 6'h3F) begin
      gap_reg <= gap_reg + 6'h01;
    end
  end

  AST_TICK_PERIOD: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R1 R2 R3 R13 R14
    conv_tick && gap_ok_reg && gap_per_reg == period && $stable(period)
      |-> gap_reg == {1'b0, period})
    else $error("Converter tick spacing does not match the selected period.");

  AST_DIV1_EVERY: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R3
    cfg_reg[`DCC_CFG_SRC] && period == 5'h01 && en_reg && conv_tick && $stable(period)
      |=> conv_tick)
    else $error("Divide by one must tick every cycle.");

  AST_SLEEP_OFF: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R5 R15
    i_sleep |=> !o_conv_enable ##1 (st_reg == dcc_pkg::ST_DIS))
    else $error("Converter not disabled in sleep.");

  AST_FLOAT: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R6
    i_sleep && one_cell_reg |=> o_out_to_battery == !$past(cfg_reg[`DCC_CFG_FLOAT]))
    else $error("Sleep output connection wrong.");

  AST_TWO_CELL: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R15
    !one_cell_reg && $stable(one_cell_reg) |=> !o_conv_enable && !o_switch_on)
    else $error("Converter active in two-cell operation.");

  AST_SKIP: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R7
    en_reg && conv_tick && i_duty_req < min_cyc |=> !o_switch_on && o_pulse_skipped)
    else $error("Short pulse was not skipped.");

  AST_WIDTH4: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R7
    en_reg && conv_tick && i_duty_req == 8'h04 ##1 (!conv_tick && en_reg)[*4] |->
      $past(o_switch_on, 3) && $past(o_switch_on, 1) ##1 !o_switch_on)
    else $error("Pulse width differs from the demand.");

  AST_SWITCH: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R8
    i_sfr_wr && i_sfr_addr == `DCC_ADDR_CONTROL |=> o_switch_small == $past(i_sfr_wdata[5]))
    else $error("Switch size does not follow the control write.");

  AST_ADC_QUIET: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R10
    o_adc_sync && o_switch_on |-> !o_adc_track_en)
    else $error("ADC tracking during switch on time.");

  AST_ADC_NOSYNC: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R10
    !o_adc_sync |-> o_adc_track_en && !o_adc_sar_tick)
    else $error("ADC aligned while sync is off.");

  AST_TARGET: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R12
    i_sfr_wr && i_sfr_addr == `DCC_ADDR_CONTROL && i_sfr_wdata[2:0] == 3'b111
      |=> o_target_mv == 12'hCE4)
    else $error("Target voltage decode wrong.");

  COV_SKIP: cover property (@(posedge i_ref_clk) disable iff (i_srst) o_pulse_skipped);
  COV_FLOAT: cover property (@(posedge i_ref_clk) disable iff (i_srst)
    i_sleep && one_cell_reg && cfg_reg[`DCC_CFG_FLOAT]);
  COV_SYNC_TICK: cover property (@(posedge i_ref_clk) disable iff (i_srst) o_adc_sar_tick);
  COV_LOCAL_TICK: cover property (@(posedge i_ref_clk) disable iff (i_srst)
    conv_tick && !cfg_reg[`DCC_CFG_SRC]);

endmodule : dcc_converter_control

// *** bench/dcc_stage_model.sv ***
// Analog power stage stand-in that presents the regulation demand to the control.
`timescale 1ns/10ps

module dcc_stage_model (
  // Clock
  input  wire logic       i_ref_clk,
  // Load demand chosen by the bench and converter state from the control
  input  wire logic [7:0] i_load_demand,
  input  wire logic       i_conv_enable,
  // Regulation demand back to the control
  output logic      [7:0] o_duty_req
);
  // The loop output only moves just after a clock edge, so it is settled at every tick.
  // It rests at zero on-time while the converter is disabled, as an idle amplifier would.
  always_ff @(posedge i_ref_clk) begin
    o_duty_req <= i_conv_enable ? i_load_demand : 8'h00;
  end
endmodule : dcc_stage_model

// *** bench/test_dcc_converter_control.sv ***
// Self-checking bench for the converter control: registers, clocking, pulse skip, sleep.
`timescale 1ns/10ps

module test_dcc_converter_control;
  logic        i_ref_clk, i_srst, i_sfr_wr, i_sfr_rd, i_sleep, i_converter_mode_strap;
  logic [7:0]  i_sfr_addr, i_sfr_wdata, i_duty_req, o_sfr_rdata, load_demand;
  logic [2:0]  o_output_voltage_select;
  logic [11:0] o_target_mv;
  logic        o_conv_enable, o_conv_tick, o_conv_clk_inv, o_switch_on, o_pulse_skipped;
  logic        o_switch_small, o_peak_limit_high, o_out_to_battery;
  logic        o_adc_sync, o_adc_track_en, o_adc_sar_tick, o_adc_sar_inv;
  int          mismatches, n_tests, cyc, n;
  // Expected target voltages in millivolts, one per select code.
  logic [11:0] mv [8] = '{12'h708, 12'h76C, 12'h7D0, 12'h834, 12'h960, 12'hA8C, 12'hBB8, 12'hCE4};
  // Pulse skip cases: width code, demanded cycles, whether the switch should fire.
  logic [1:0]  pw_code [7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [7:0]  pw_duty [7] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h02, 8'h03, 8'h04};
  logic        pw_on   [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  dcc_converter_control DUT (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
    .o_sfr_rdata(o_sfr_rdata), .i_sleep(i_sleep),
    .i_converter_mode_strap(i_converter_mode_strap), .i_duty_req(i_duty_req),
    .o_conv_enable(o_conv_enable), .o_conv_tick(o_conv_tick), .o_conv_clk_inv(o_conv_clk_inv),
    .o_switch_on(o_switch_on), .o_pulse_skipped(o_pulse_skipped),
    .o_switch_small(o_switch_small), .o_peak_limit_high(o_peak_limit_high),
    .o_out_to_battery(o_out_to_battery), .o_output_voltage_select(o_output_voltage_select),
    .o_target_mv(o_target_mv), .o_adc_sync(o_adc_sync), .o_adc_track_en(o_adc_track_en),
    .o_adc_sar_tick(o_adc_sar_tick), .o_adc_sar_inv(o_adc_sar_inv));

  dcc_stage_model stage (.i_ref_clk(i_ref_clk), .i_load_demand(load_demand),
    .i_conv_enable(o_conv_enable), .o_duty_req(i_duty_req));

  // The reference clock, 20 ns period.
  always #10 i_ref_clk = ~i_ref_clk;

  // Cycle ceiling so a hung wait still reaches the verdict.
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // Compares a multi-bit result.
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  // Compares a single flag.
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // One register write; the strobe is held for exactly one taking edge.
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_sfr_addr  <= a;
    i_sfr_wdata <= d;
    i_sfr_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_sfr_wr    <= 1'b0;
    #1;
  endtask : sfr_wr

  // One register read, checked once the registered data has landed.
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    i_sfr_addr <= a;
    i_sfr_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_sfr_rd   <= 1'b0;
    #1;
    chk_val({4'h0, o_sfr_rdata}, {4'h0, exp});
  endtask : sfr_rd

  // Counts falling edges up to and including the next tick, bounded.
  task automatic wait_tick(output int k);
    k = 0;
    do begin
      @(negedge i_ref_clk);
      k++;
    end while (o_conv_tick !== 1'b1 && k < 100);
  endtask : wait_tick

  // Resets with the given cell strap; reset spans four clock cycles.
  task automatic do_reset(input logic strap);
    @(posedge i_ref_clk);
    i_srst                 <= 1'b1;
    i_converter_mode_strap <= strap;
    repeat (4) @(posedge i_ref_clk);
    i_srst                 <= 1'b0;
  endtask : do_reset

  // Prints the verdict and stops.
  task automatic tally_and_finish();
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence.
  initial begin
    i_ref_clk = 1'b0;
    i_srst = 1'b1;
    i_converter_mode_strap = 1'b1;
    i_sleep = 1'b0;
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
    i_sfr_addr = 8'h00;
    i_sfr_wdata = 8'h00;
    load_demand = 8'h00;
    do_reset(1'b1);
    // Reset values and an unmapped address.
    sfr_rd(8'h97, 8'h21);
    sfr_rd(8'h96, 8'h00);
    sfr_rd(8'h55, 8'h00);
    chk_val(o_target_mv, mv[1]);
    chk_bit(o_switch_small, 1'b1);
    // Every voltage code, large switches, reserved bit written as zero.
    for (int v = 0; v < 8; v++) begin
      sfr_wr(8'h97, {5'h00, 3'(v)});
      chk_val(o_target_mv, mv[v]);
      chk_val({9'h000, o_output_voltage_select}, 12'(v));
      chk_bit(o_switch_small, 1'b0);
      sfr_rd(8'h97, {5'h00, 3'(v)});
    end
    // Local oscillator period, inversion ignored there.
    sfr_wr(8'h96, 8'h68);
    chk_bit(o_conv_clk_inv, 1'b0);
    wait_tick(n);
    wait_tick(n);
    chk_val(12'(n), 12'h015);
    // System clock with each divider code, inverted.
    for (int d = 0; d < 4; d++) begin
      sfr_wr(8'h96, {1'b0, 2'(d), 2'h1, 1'(d), 2'h1});
      sfr_rd(8'h96, {1'b0, 2'(d), 2'h1, 1'(d), 2'h1});
      chk_bit(o_conv_clk_inv, 1'b1);
      chk_bit(o_peak_limit_high, 1'(d));
      wait_tick(n);
      wait_tick(n);
      chk_val(12'(n), 12'(1 << d));
    end
    // Pulse skipping with ADC sync on, system clock divided by 8.
    sfr_wr(8'h96, 8'h61);
    for (int p = 0; p < 7; p++) begin
      sfr_wr(8'h97, {pw_code[p], 3'h1, 3'h0});
      load_demand <= pw_duty[p];
      wait_tick(n);
      wait_tick(n);
      chk_bit(o_adc_sar_tick, 1'b1);
      chk_bit(o_adc_sar_inv, 1'b1);
      @(negedge i_ref_clk);
      chk_bit(o_switch_on, pw_on[p]);
      chk_bit(o_pulse_skipped, ~pw_on[p]);
      chk_bit(o_adc_track_en, ~pw_on[p]);
    end
    // Sync off: no alignment, tracking free.
    sfr_wr(8'h97, 8'h00);
    wait_tick(n);
    chk_bit(o_adc_sync, 1'b0);
    chk_bit(o_adc_sar_tick, 1'b0);
    chk_bit(o_adc_sar_inv, 1'b0);
    @(negedge i_ref_clk);
    chk_bit(o_adc_track_en, 1'b1);
    // Sleep: converter off, output tied to battery, then floating.
    @(posedge i_ref_clk);
    i_sleep <= 1'b1;
    repeat (3) @(negedge i_ref_clk);
    chk_bit(o_conv_enable, 1'b0);
    chk_bit(o_out_to_battery, 1'b1);
    chk_bit(o_switch_on, 1'b0);
    wait_tick(n);
    chk_val(12'(n), 12'h064);
    sfr_wr(8'h96, 8'h63);
    repeat (2) @(negedge i_ref_clk);
    chk_bit(o_out_to_battery, 1'b0);
    @(posedge i_ref_clk);
    i_sleep <= 1'b0;
    repeat (3) @(negedge i_ref_clk);
    chk_bit(o_conv_enable, 1'b1);
    // Two-cell strap keeps the converter off and its clock stopped, checked out of sleep after reset.
    do_reset(1'b0);
    repeat (5) @(negedge i_ref_clk);
    chk_bit(o_conv_enable, 1'b0);
    wait_tick(n);
    chk_val(12'(n), 12'h064);
    tally_and_finish();
  end
endmodule : test_dcc_converter_control
